// File: sim/crc_cfg_sva.sv
// Port checker for crc_cfg_top.
// Bound to every instance; single clock domain.
`timescale 1ns/100ps
module crc_cfg_sva
  import crc_cfg_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic [7:0] ADDR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic IN_VALID_I,
  input wire logic IN_READY_O,
  input wire xfer_t IN_XFER_I,
  input wire logic OUT_VALID_O,
  input wire logic OUT_READY_I,
  input wire out_word_t OUT_WORD_O,
  input wire logic UNALIGNED_ERR_O,
  input wire logic CHK_IP_MODE_O,
  input wire logic [4:0] POLY_LEN_M1_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  chk_ctrl_zero_bits: assert property (RD_I && ADDR_I == 8'h0 |=>
    (RDATA_O & 32'hc6ff6038) == 0)
    else $error("reserved ctrl bits set");
  chk_ptr_upper_zero: assert property (RD_I && ADDR_I[7:4] inside {4'h1, 4'h2} |=>
    RDATA_O[31:16] == 0)
    else $error("pointer upper bits set");
  chk_unmapped_zero: assert property (RD_I && ADDR_I >= 8'h30 |=> RDATA_O == 32'h0)
    else $error("unmapped read nonzero");
  chk_err_cause: assert property (UNALIGNED_ERR_O |->
    $past(IN_VALID_I && IN_READY_O && IN_XFER_I.byte_count != 3'h4))
    else $error("error without unaligned offer");
  chk_refused_dropped: assert property (
    (IN_VALID_I && IN_READY_O && !OUT_VALID_O ##1 UNALIGNED_ERR_O) |-> !OUT_VALID_O)
    else $error("refused word queued");
  chk_poly_ip_zero: assert property (CHK_IP_MODE_O |-> POLY_LEN_M1_O == 5'h0)
    else $error("poly length in ip mode");
  chk_crc_off_zero: assert property (OUT_VALID_O && !OUT_WORD_O.through_unit |->
    OUT_WORD_O.crc_data == 0)
    else $error("crc data while disabled");
  chk_out_word_hold: assert property (OUT_VALID_O && !OUT_READY_I |=>
    OUT_VALID_O && $stable(OUT_WORD_O))
    else $error("output word dropped");
  chk_aligned_out: assert property (IN_VALID_I && IN_READY_O &&
    IN_XFER_I.byte_count == 3'h4 |=> OUT_VALID_O)
    else $error("aligned word lost");
  cover property (UNALIGNED_ERR_O);
  cover property (OUT_VALID_O && !IN_READY_O);
  cover property (CHK_IP_MODE_O && OUT_VALID_O);
endmodule
bind crc_cfg_top crc_cfg_sva crc_cfg_sva_i (.*);

// File: sim/crc_cfg_top_bench.sv
// Self-checking bench for crc_cfg_top with the feeder model.
// Expected words are rebuilt from the control word; expected pointers are summed from transfer byte counts.
`timescale 1ns/100ps
`include "crc_cfg_regs.svh"
module crc_cfg_top_bench import crc_cfg_pkg::*;;
  logic CLOCK_I = 0, RESETN_I = 0, WR_I = 0, RD_I = 0, OUT_READY_I = 0, send = 0;
  logic [7:0] ADDR_I = 0;
  logic [31:0] WDATA_I = 0, RDATA_O, q [4];
  logic [3:0] BLOCK_RESTART_I = 0, PATTERN_MODE_I = 0, PATTERN_HIT_I = 0;
  logic IN_VALID_I, IN_READY_O, OUT_VALID_O, UNALIGNED_ERR_O, busy, err;
  logic CHK_ENABLE_O, CHK_IP_MODE_O, CHK_REFLECT_O, APPEND_O;
  logic [4:0] POLY_LEN_M1_O;
  logic [2:0] CHAN_SEL_O;
  logic [1:0] dly = 0;
  xfer_t IN_XFER_I, xf = '0;
  out_word_t OUT_WORD_O;
  logic [15:0] src [4] = '{default: '0}, dst [4] = '{default: '0};
  int n_fail = 0, n_compared = 0;
  crc_cfg_top crc_cfg_top_i (.*);
  dma_feed_model dma_feed_model_i (.clk_i(CLOCK_I), .resetn_i(RESETN_I), .send_i(send),
    .xfer_i(xf), .delay_i(dly), .busy_o(busy), .valid_o(IN_VALID_I), .ready_i(IN_READY_O),
    .xfer_o(IN_XFER_I));
  initial forever #5 CLOCK_I = ~CLOCK_I;
  initial begin
    #300000 n_fail++;
    summarize();
  end
  function automatic logic [31:0] reord(logic [31:0] d, logic [1:0] c);
    case (c)
      2'h0: return d;
      2'h1: return {d[7:0], d[15:8], d[23:16], d[31:24]};
      2'h2: return {d[15:0], d[31:16]};
      default: return {d[23:16], d[31:24], d[7:0], d[15:8]};
    endcase
  endfunction
  function automatic logic [31:0] rev(logic [31:0] d);
    for (int i = 0; i < 32; i++) rev[i] = d[31-i];
  endfunction
  task automatic check(input logic [65:0] seen, input logic [65:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLOCK_I);
    WR_I <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLOCK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLOCK_I);
    RD_I <= 1'b0;
    #1 check(RDATA_O, e);
  endtask
  task automatic put(input xfer_t x);
    @(posedge CLOCK_I);
    xf <= x;
    dly <= 2'($urandom);
    send <= 1'b1;
    @(posedge CLOCK_I);
    send <= 1'b0;
    repeat (30) begin
      @(posedge CLOCK_I);
      #1 err = UNALIGNED_ERR_O;
      if (!busy) break;
    end
  endtask
  task automatic take(input logic [65:0] e);
    // Step off the edge so the FIFO count has settled
    #1;
    repeat (20) if (!OUT_VALID_O) @(posedge CLOCK_I);
    #1 check({OUT_VALID_O, OUT_WORD_O}, e);
    @(posedge CLOCK_I);
    OUT_READY_I <= 1'b1;
    @(posedge CLOCK_I);
    OUT_READY_I <= 1'b0;
  endtask
  task automatic ptrs();
    for (int c = 0; c < 4; c++) begin
      rd(`SRC_PROG_OFS_BASE + 8'(4 * c), {16'h0, src[c]});
      rd(`DST_PROG_OFS_BASE + 8'(4 * c), {16'h0, dst[c]});
    end
  endtask
  initial begin
    logic [31:0] c, r;
    xfer_t x;
    logic [65:0] e;
    void'($urandom(70));
    repeat (6) @(posedge CLOCK_I);
    RESETN_I <= 1'b1;
    rd(`CHK_CTRL_OFS, 32'h0);
    rd(8'h40, 32'h0);
    ptrs();
    wr(`CHK_CTRL_OFS, 32'hffff_ffff);
    rd(`CHK_CTRL_OFS, 32'h3900_9f87);
    check({APPEND_O, CHK_IP_MODE_O, POLY_LEN_M1_O}, 7'h20);
    wr(`CHK_CTRL_OFS, 32'h45);
    rd(`CHK_CTRL_OFS, 32'h45);
    check({APPEND_O, CHAN_SEL_O}, 4'hd);
    for (int i = 0; i < 9; i++) begin
      c = ($urandom & 32'h0100_9f00) | {2'h0, i[1:0], i[2], 19'h0, i < 8, 7'h0};
      wr(`CHK_CTRL_OFS, c | ($urandom & 32'hc6ff6038));
      rd(`CHK_CTRL_OFS, c);
      check({CHK_ENABLE_O, CHK_IP_MODE_O, CHK_REFLECT_O, POLY_LEN_M1_O},
        {c[7], c[15], c[24], c[15] ? 5'h0 : c[12:8]});
      x = {2'($urandom), 3'h2, 32'($urandom)};
      if (c[27]) begin
        put(x);
        check({err, OUT_VALID_O}, 2'h2);
      end
      x.byte_count = c[27] ? 3'h4 : 3'(1 + $urandom_range(3));
      r = reord(x.data, c[29:28]);
      put(x);
      src[x.channel] += 16'(x.byte_count);
      dst[x.channel] += 16'(x.byte_count);
      e = {1'b1, c[7] ? (c[24] ? rev(r) : r) : 32'h0, c[27] ? r : x.data, c[7]};
      take(e);
    end
    ptrs();
    wr(`CHK_CTRL_OFS, 32'h80);
    for (int i = 0; i < 4; i++) begin
      x = {2'h3, 3'h4, 32'($urandom)};
      q[i] = x.data;
      put(x);
      src[3] += 16'h4;
      dst[3] += 16'h4;
    end
    check(IN_READY_O, 1'b0);
    for (int i = 0; i < 4; i++) take({1'b1, q[i], q[i], 1'b1});
    #1 check(IN_READY_O, 1'b1);
    @(posedge CLOCK_I);
    PATTERN_MODE_I <= 4'h1;
    PATTERN_HIT_I <= 4'h3;
    @(posedge CLOCK_I);
    PATTERN_HIT_I <= 4'h0;
    BLOCK_RESTART_I <= 4'h8;
    @(posedge CLOCK_I);
    BLOCK_RESTART_I <= 4'h0;
    src[0] = 16'h0;
    src[3] = 16'h0;
    dst[3] = 16'h0;
    ptrs();
    summarize();
  end
endmodule

// File: sim/dma_feed_model.sv
// Feeder model: one transfer per send pulse, offered 1..4 cycles after the pulse is sampled.
// Holds valid and payload until taken at a rising edge.
`timescale 1ns/100ps
module dma_feed_model
  import crc_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic send_i,
  input wire xfer_t xfer_i,
  input wire logic [1:0] delay_i,
  output logic busy_o,
  output logic valid_o,
  input wire logic ready_i,
  output xfer_t xfer_o
);
  logic [1:0] cnt;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_o <= 1'b0;
      valid_o <= 1'b0;
      cnt <= 2'h0;
      xfer_o <= '0;
    end else if (send_i) begin
      busy_o <= 1'b1;
      cnt <= delay_i;
      xfer_o <= xfer_i;
    end else if (busy_o && !valid_o) begin
      valid_o <= cnt == 2'h0;
      cnt <= cnt - 2'h1;
    end else if (valid_o && ready_i) begin
      busy_o <= 1'b0;
      valid_o <= 1'b0;
      // Released payload must not keep showing the old word
      xfer_o <= ~xfer_o;
    end
  end
endmodule

// File: verilog/crc_cfg_pkg.sv
// Types shared by the checksum configuration block.
// Offsets and field positions live in crc_cfg_regs.svh.
package crc_cfg_pkg;
  typedef enum logic [1:0] {
    ORDER_NONE,
    ORDER_WORD_SWAP,
    ORDER_HALF_SWAP,
    ORDER_HALF_BYTE_SWAP
  } byte_order_t;
  typedef struct packed {
    logic [1:0] channel;
    logic [2:0] byte_count;
    logic [31:0] data;
  } xfer_t;
  typedef struct packed {
    logic [31:0] crc_data;
    logic [31:0] dest_data;
    logic through_unit;
  } out_word_t;
endpackage

// File: verilog/crc_cfg_regs.svh
// Register offsets, field positions and reset values of the checksum config block.
// Included by the package user; holds definitions only.
`ifndef CRC_CFG_REGS_SVH
`define CRC_CFG_REGS_SVH
`define CHK_CTRL_OFS 8'h00
`define SRC_PROG_OFS_BASE 8'h10
`define DST_PROG_OFS_BASE 8'h20
`define CHK_CTRL_RESET 32'h0000_0000
`define PROG_RESET 16'h0000
`define BYTE_ORDER_HI 29
`define BYTE_ORDER_LO 28
`define WRITE_REORDER_BIT 27
`define BIT_ORDER_BIT 24
`define CHK_TYPE_BIT 15
`define POLY_LEN_HI 12
`define POLY_LEN_LO 8
`define CHK_ENABLE_BIT 7
`define APPEND_BIT 6
`define CHAN_SEL_HI 2
`define CHAN_SEL_LO 0
`define CHK_CTRL_WMASK 32'h3900_9fc7
`define NUM_CHAN 4
`define FIFO_DEPTH 4
`endif

// File: verilog/crc_cfg_top.sv
// Checksum unit configuration, data reordering and per-channel progress pointers.
// Assumes a same-clock register port and a same-clock DMA datapath with valid/ready.
// How it works
// (RL1) Byte order 00 passes bytes; 01 reverses all four bytes.
// (RL2) Code 10 swaps half-words; code 11 swaps bytes inside each half-word.
// (RL3) Write-reorder set sends reordered data to destination, else source data.
// (RL4) Write-reorder set blocks append bit and refuses unaligned transfers.
// (RL5) Checksum type bit 15: 1 IP header checksum, 0 shift-register CRC.
// (RL6) IP header mode: bit order 1 reflects checksum input, 0 keeps MSb first.
// (RL7) CRC mode: bit order 1 reflects CRC input, 0 keeps MSb first.
// (RL8) Poly length field holds length minus one; ignored in IP header mode.
// (RL9) Enable bit routes channel transfers through the checksum unit.
// (RL10) Unimplemented control bits read zero and ignore writes.
// (RL11) Per-channel 16-bit source pointer, upper bits zero, clears at reset.
// (RL12) Pattern detect in pattern mode resets the source pointer.
// (RL13) Per-channel 16-bit destination pointer, all ones means byte 65,535.
// (RL14) Pointers advance by bytes moved and clear on block restart.
`timescale 1ns/100ps
`include "crc_cfg_regs.svh"
module crc_cfg_top
  import crc_cfg_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  // Register port
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // Transfer input from channel datapath
  input wire logic IN_VALID_I,
  output logic IN_READY_O,
  input wire xfer_t IN_XFER_I,
  // Per-channel pointer events
  input wire logic [`NUM_CHAN-1:0] BLOCK_RESTART_I,
  input wire logic [`NUM_CHAN-1:0] PATTERN_MODE_I,
  input wire logic [`NUM_CHAN-1:0] PATTERN_HIT_I,
  // Output toward checksum engine and destination
  output logic OUT_VALID_O,
  input wire logic OUT_READY_I,
  output out_word_t OUT_WORD_O,
  output logic UNALIGNED_ERR_O,
  // Checksum engine configuration
  output logic CHK_ENABLE_O,
  output logic CHK_IP_MODE_O,
  output logic CHK_REFLECT_O,
  output logic [4:0] POLY_LEN_M1_O,
  output logic APPEND_O,
  output logic [2:0] CHAN_SEL_O
);
  logic [31:0] checksum_control;
  logic [15:0] source_progress_pointer [`NUM_CHAN];
  logic [15:0] destination_progress_pointer [`NUM_CHAN];
  logic [31:0] next_control;
  logic [31:0] next_rdata;
  byte_order_t byte_order_select;
  logic write_reorder_enable;
  logic bit_order_select;
  logic checksum_type_select;
  logic checksum_enable;
  logic [31:0] reordered;
  logic [31:0] crc_word;
  logic in_take;
  logic aligned;
  logic fifo_in_valid;
  logic fifo_in_ready;
  out_word_t fifo_in_word;
  logic [1:0] rd_chan;
  assign byte_order_select = byte_order_t'(checksum_control[`BYTE_ORDER_HI:`BYTE_ORDER_LO]);
  assign write_reorder_enable = checksum_control[`WRITE_REORDER_BIT];
  assign bit_order_select = checksum_control[`BIT_ORDER_BIT];
  assign checksum_type_select = checksum_control[`CHK_TYPE_BIT];
  assign checksum_enable = checksum_control[`CHK_ENABLE_BIT];
  assign CHK_ENABLE_O = checksum_enable;
  assign CHK_IP_MODE_O = checksum_type_select; // RL5
  assign CHK_REFLECT_O = bit_order_select;
  assign APPEND_O = checksum_control[`APPEND_BIT];
  assign CHAN_SEL_O = checksum_control[`CHAN_SEL_HI:`CHAN_SEL_LO];
  // Length field has no meaning for the IP header sum, so it is masked there
  assign POLY_LEN_M1_O = checksum_type_select ? 5'h00 :
    checksum_control[`POLY_LEN_HI:`POLY_LEN_LO]; // RL8
  // Control write: masked so unimplemented bits stay zero
  always_comb begin
    next_control = (WDATA_I & `CHK_CTRL_WMASK) | (checksum_control & ~`CHK_CTRL_WMASK); // RL10
    // Append cannot be set while reordered data goes to the destination
    if (next_control[`WRITE_REORDER_BIT]) begin
      next_control[`APPEND_BIT] = 1'b0; // RL4
    end
  end
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      checksum_control <= `CHK_CTRL_RESET;
    end else if (WR_I && ADDR_I == `CHK_CTRL_OFS) begin
      checksum_control <= next_control;
    end
  end
  // Byte reordering of the source word
  always_comb begin
    case (byte_order_select)
      ORDER_NONE: reordered = IN_XFER_I.data; // RL1
      ORDER_WORD_SWAP: reordered = {IN_XFER_I.data[7:0], IN_XFER_I.data[15:8],
        IN_XFER_I.data[23:16], IN_XFER_I.data[31:24]}; // RL1
      ORDER_HALF_SWAP: reordered = {IN_XFER_I.data[15:0], IN_XFER_I.data[31:16]}; // RL2
      ORDER_HALF_BYTE_SWAP: reordered = {IN_XFER_I.data[23:16], IN_XFER_I.data[31:24],
        IN_XFER_I.data[7:0], IN_XFER_I.data[15:8]}; // RL2
      default: reordered = IN_XFER_I.data;
    endcase
  end
  // Bit reflection applies the same way in both checksum modes
  always_comb begin
    crc_word = reordered;
    if (bit_order_select) begin
      for (int i = 0; i < 32; i++) begin
        crc_word[i] = reordered[31-i]; // RL6 RL7
      end
    end
  end
  // Only full words are accepted while write-reorder is on
  assign aligned = (IN_XFER_I.byte_count == 3'h4);
  assign fifo_in_valid = IN_VALID_I & ~(write_reorder_enable & ~aligned);
  assign IN_READY_O = fifo_in_ready | (write_reorder_enable & ~aligned); // RL4
  assign in_take = IN_VALID_I & IN_READY_O;
  always_comb begin
    fifo_in_word.through_unit = checksum_enable; // RL9
    fifo_in_word.crc_data = checksum_enable ? crc_word : 32'h0000_0000; // RL9
    fifo_in_word.dest_data = write_reorder_enable ? reordered : IN_XFER_I.data; // RL3
  end
  word_fifo #(
    .WIDTH($bits(out_word_t)),
    .DEPTH(`FIFO_DEPTH)
  ) word_fifo_i (
    .clk_i(CLOCK_I),
    .resetn_i(RESETN_I),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_word),
    .out_valid_o(OUT_VALID_O),
    .out_ready_i(OUT_READY_I),
    .out_data_o(OUT_WORD_O)
  );
  // Unaligned refusal flagged for one cycle
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      UNALIGNED_ERR_O <= 1'b0;
    end else begin
      UNALIGNED_ERR_O <= IN_VALID_I & write_reorder_enable & ~aligned; // RL4
    end
  end
  // Progress pointers, one pair per channel; wrap at 16 bits
  generate
    for (genvar ch = 0; ch < `NUM_CHAN; ch++) begin : g_chan
      logic moved;
      assign moved = in_take & fifo_in_valid & (IN_XFER_I.channel == 2'(ch));
      always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          source_progress_pointer[ch] <= `PROG_RESET; // RL11
        end else if (BLOCK_RESTART_I[ch]) begin
          source_progress_pointer[ch] <= `PROG_RESET; // RL14
        end else if (PATTERN_MODE_I[ch] && PATTERN_HIT_I[ch]) begin
          source_progress_pointer[ch] <= `PROG_RESET; // RL12
        end else if (moved) begin
          source_progress_pointer[ch] <= source_progress_pointer[ch] +
            {13'h0000, IN_XFER_I.byte_count}; // RL14
        end
      end
      always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          destination_progress_pointer[ch] <= `PROG_RESET;
        end else if (BLOCK_RESTART_I[ch]) begin
          destination_progress_pointer[ch] <= `PROG_RESET; // RL14
        end else if (moved) begin
          destination_progress_pointer[ch] <= destination_progress_pointer[ch] +
            {13'h0000, IN_XFER_I.byte_count}; // RL13
        end
      end
    end
  endgenerate
  // Register read, data in the following cycle
  assign rd_chan = ADDR_I[3:2];
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (ADDR_I == `CHK_CTRL_OFS) begin
      next_rdata = checksum_control;
    end else if (ADDR_I[7:4] == 4'(`SRC_PROG_OFS_BASE >> 4) && ADDR_I[1:0] == 2'h0) begin
      next_rdata = {16'h0000, source_progress_pointer[rd_chan]}; // RL11
    end else if (ADDR_I[7:4] == 4'(`DST_PROG_OFS_BASE >> 4) && ADDR_I[1:0] == 2'h0) begin
      next_rdata = {16'h0000, destination_progress_pointer[rd_chan]}; // RL13
    end
  end
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      RDATA_O <= 32'h0000_0000;
    end else if (RD_I) begin
      RDATA_O <= next_rdata;
    end else begin
      RDATA_O <= 32'h0000_0000;
    end
  end
endmodule

// File: verilog/word_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Same clock on both sides; depth a power of two.
`timescale 1ns/100ps
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr];
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
